// ---- smbus_status.sv ----
// status and error reporting of the master management bus and eeprom init
// assumes an apb master on pclk, engine event pulses on pclk, straps and bus pins async
// How it works
// [R1] slave address readable in status bits 7:1
// [R2] master address readable in status bits 15:9
// [R3] done bit set when init ends or fails
// [R4] unexpected nack sets sticky bit 25
// [R5] lost arbitration triggers automatic retry
// [R6] sixteen losses abort and set bit 26
// [R7] misplaced start or stop sets bit 27
// [R8] bad init checksum sets bit 28
// [R9] missing end command also sets bit 28
// [R10] unmapped register init sets bit 29
// [R11] ignore-checksum control suppresses checksum errors
// [R12] ignore-arbitration control suppresses retry and abort
// [R13] hardware set wins over software clear
// [R14] reserved status bits read zero, writes ignored
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "smbus_regs.svh"
module smbus_status import smbus_status_pkg::*; (
  input wire logic pclk, // core clock, 25 mhz
  input wire logic presetn, // fundamental reset, async, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [6:0] slave_addr_strap, // slave address strap pins
  input wire logic [6:0] master_addr_strap, // master address strap pins
  input wire logic init_mode_strap, // eeprom init at reset strap
  input wire logic scl_in, // bus clock pin
  input wire logic sda_in, // bus data pin
  input wire logic byte_active, // engine mid-byte, no condition expected
  input wire logic nack_evt, // engine saw an unexpected nack
  input wire logic arb_lost_evt, // engine lost one arbitration attempt
  input wire logic arb_won_evt, // engine won arbitration
  input wire logic init_byte_vld, // eeprom image byte strobe
  input wire logic [7:0] init_byte, // eeprom image byte
  input wire logic init_cmd_done, // configuration-done command seen
  input wire logic init_end, // eeprom image read finished
  input wire logic init_unmapped, // image targets an unmapped register
  output logic arb_retry, // pulse: re-arbitrate same transaction
  output logic arb_abort // pulse: transaction aborted
);
  // register file state
  logic pready_r, pready_nxt; // apb ready
  logic pslverr_r, pslverr_nxt; // apb error
  logic [31:0] prdata_r, prdata_nxt; // apb read data
  logic [1:0] ctl_r, ctl_nxt; // [0] ignore_arbitration, [1] ignore_init_sum
  err_vec_t err_r, err_nxt; // sticky error flags
  // strap capture state
  logic [14:0] strap_s1_r, strap_s2_r; // two-flop synchroniser for straps
  logic [1:0] rel_r; // counts edges after reset release
  logic cap_r, cap_nxt; // straps captured
  logic [6:0] slave_bus_addr_r, slave_bus_addr_nxt; // captured slave address
  logic [6:0] master_bus_addr_r, master_bus_addr_nxt; // captured master address
  // init and arbitration state
  init_state_t st_r, st_nxt; // eeprom init state
  logic [7:0] sum_r, sum_nxt; // running image byte sum
  logic cmd_seen_r, cmd_seen_nxt; // configuration-done seen
  arb_cnt_t lost_cnt_r, lost_cnt_nxt; // consecutive losses
  logic retry_r, retry_nxt; // retry pulse
  logic abort_r, abort_nxt; // abort pulse
  // combinational helpers
  logic start_det, stop_det; // bus conditions from detector
  logic access; // write/read completes this edge
  logic sum_bad, noend_set, csum_set; // checksum error causes
  err_vec_t err_set, err_clr; // flag set and clear vectors
  logic ign_arb, ign_sum; // control bits

  // true when the apb address hits a given register offset
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  // status word as software sees it
  function automatic logic [31:0] sts_word(input logic [6:0] sa, input logic [6:0] ma,
                                           input logic dn, input err_vec_t e);
    sts_word = `ZERO_WORD;
    sts_word[`SADDR_HI:`SADDR_LO] = sa;
    sts_word[`MADDR_HI:`MADDR_LO] = ma;
    sts_word[`DONE_BIT] = dn;
    sts_word[`ERR_HI:`ERR_LO] = e;
  endfunction : sts_word

  // start/stop detection on the synchronised pins
  bus_cond_detect u_cond (
    .pclk(pclk),
    .presetn(presetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  assign ign_arb = ctl_r[0];
  assign ign_sum = ctl_r[1];
  assign access = psel & penable & pready_r;

  // apb slave: one wait state, error and zero data for unmapped addresses
  always_comb begin
    pready_nxt = psel & penable & ~pready_r;
    pslverr_nxt = pready_nxt & ~(hit(paddr, `STS_OFF) | hit(paddr, `CTL_OFF));
    prdata_nxt = prdata_r;
    if (pready_nxt & ~pwrite) begin
      if (hit(paddr, `STS_OFF)) begin // status
        prdata_nxt = sts_word(slave_bus_addr_r, master_bus_addr_r, st_r == init_fin, err_r); // R1 R2 R14
      end else if (hit(paddr, `CTL_OFF)) begin // control
        prdata_nxt = `ZERO_WORD;
        prdata_nxt[`IGN_ARB_BIT] = ctl_r[0];
        prdata_nxt[`IGN_SUM_BIT] = ctl_r[1];
      end else begin // unmapped
        prdata_nxt = `ZERO_WORD;
      end
    end
    ctl_nxt = ctl_r;
    if (access & pwrite & hit(paddr, `CTL_OFF)) begin
      ctl_nxt = {pwdata[`IGN_SUM_BIT], pwdata[`IGN_ARB_BIT]};
    end
  end

  // strap capture once the synchronised straps are valid after release
  always_comb begin
    cap_nxt = cap_r | (rel_r == `STRAP_READY);
    slave_bus_addr_nxt = slave_bus_addr_r;
    master_bus_addr_nxt = master_bus_addr_r;
    if (~cap_r & (rel_r == `STRAP_READY)) begin
      slave_bus_addr_nxt = strap_s2_r[6:0]; // R1
      master_bus_addr_nxt = strap_s2_r[13:7]; // R2
    end
  end

  // eeprom init sequence and checksum
  always_comb begin
    st_nxt = st_r;
    sum_nxt = sum_r;
    cmd_seen_nxt = cmd_seen_r;
    sum_bad = 1'h0;
    noend_set = 1'h0;
    case (st_r)
      init_idle: begin // wait for strap capture
        if (~cap_r & (rel_r == `STRAP_READY) & strap_s2_r[14]) begin
          st_nxt = init_run;
        end
      end
      init_run: begin // image streaming in
        if (init_byte_vld) begin
          sum_nxt = sum_r + init_byte;
        end
        if (init_cmd_done) begin
          cmd_seen_nxt = 1'h1;
        end
        if (init_end) begin
          sum_bad = (sum_r != `ZERO_SUM) & ~ign_sum; // R8 R11
          noend_set = ~cmd_seen_r; // R9
          st_nxt = init_fin; // R3
        end
        if (init_unmapped) begin
          st_nxt = init_fin; // R3
        end
      end
      init_fin: begin // done, held until reset
        st_nxt = init_fin;
      end
      default: begin
        st_nxt = init_idle;
      end
    endcase
  end

  assign csum_set = sum_bad | noend_set;

  // arbitration retry and abort
  always_comb begin
    lost_cnt_nxt = lost_cnt_r;
    retry_nxt = 1'h0;
    abort_nxt = 1'h0;
    if (arb_won_evt) begin
      lost_cnt_nxt = `ARB_CLR;
    end
    if (arb_lost_evt & ~ign_arb) begin // R12
      if (lost_cnt_r == `ARB_LAST) begin
        abort_nxt = 1'h1; // R6
        lost_cnt_nxt = `ARB_CLR;
      end else begin
        retry_nxt = 1'h1; // R5
        lost_cnt_nxt = lost_cnt_r + `ARB_STEP;
      end
    end
  end

  // sticky flags: write one clears, a same-cycle set wins
  always_comb begin
    err_set = '0;
    err_set[`ERR_NACK] = nack_evt; // R4
    err_set[`ERR_ARB] = abort_nxt; // R6
    err_set[`ERR_COND] = (start_det | stop_det) & byte_active; // R7
    err_set[`ERR_SUM] = (st_r == init_run) & csum_set; // R8 R9
    err_set[`ERR_UNMAP] = (st_r == init_run) & init_unmapped; // R10
    err_clr = '0;
    if (access & pwrite & hit(paddr, `STS_OFF)) begin
      err_clr = pwdata[`ERR_HI:`ERR_LO]; // R14
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_err
      assign err_nxt[gi] = (err_r[gi] & ~err_clr[gi]) | err_set[gi]; // R13
    end
  endgenerate

  // all state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'h0;
      pslverr_r <= 1'h0;
      prdata_r <= `ZERO_WORD;
      ctl_r <= 2'h0;
      err_r <= '0;
      strap_s1_r <= 15'h0000;
      strap_s2_r <= 15'h0000;
      rel_r <= 2'h0;
      cap_r <= 1'h0;
      slave_bus_addr_r <= `ZERO_ADDR;
      master_bus_addr_r <= `ZERO_ADDR;
      st_r <= init_idle;
      sum_r <= `ZERO_SUM;
      cmd_seen_r <= 1'h0;
      lost_cnt_r <= 4'h0;
      retry_r <= 1'h0;
      abort_r <= 1'h0;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      ctl_r <= ctl_nxt;
      err_r <= err_nxt;
      strap_s1_r <= {init_mode_strap, master_addr_strap, slave_addr_strap};
      strap_s2_r <= strap_s1_r;
      rel_r <= {rel_r[0], 1'h1};
      cap_r <= cap_nxt;
      slave_bus_addr_r <= slave_bus_addr_nxt;
      master_bus_addr_r <= master_bus_addr_nxt;
      st_r <= st_nxt;
      sum_r <= sum_nxt;
      cmd_seen_r <= cmd_seen_nxt;
      lost_cnt_r <= lost_cnt_nxt;
      retry_r <= retry_nxt;
      abort_r <= abort_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign arb_retry = retry_r;
  assign arb_abort = abort_r;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_ADDR_RD: assert property (pready_nxt & ~pwrite & hit(paddr, `STS_OFF) |=> // R1 R2
    prdata_r[`SADDR_HI:`SADDR_LO] == slave_bus_addr_r && prdata_r[`MADDR_HI:`MADDR_LO] == master_bus_addr_r)
    else $error("address fields wrong in status read");
  AST_DONE: assert property ((st_r == init_run) & (init_end | init_unmapped) |=> st_r == init_fin) // R3
    else $error("done bit not set after init end");
  AST_NACK: assert property (nack_evt |=> err_r[`ERR_NACK]) else $error("nack flag not set"); // R4
  AST_RETRY: assert property (arb_lost_evt & ~ign_arb & (lost_cnt_r != `ARB_LAST) |=> arb_retry && !arb_abort) // R5
    else $error("no retry after lost arbitration");
  AST_ABORT16: assert property (arb_abort |-> $past(lost_cnt_r) == `ARB_LAST && err_r[`ERR_ARB]) // R6
    else $error("abort without sixteen losses or flag");
  AST_COND: assert property ((start_det | stop_det) & byte_active |=> err_r[`ERR_COND]) // R7
    else $error("misplaced condition flag not set");
  AST_SUM: assert property ((st_r == init_run) & init_end & (sum_r != `ZERO_SUM) & ~ign_sum |=> err_r[`ERR_SUM]) // R8
    else $error("bad checksum not flagged");
  AST_NOEND: assert property ((st_r == init_run) & init_end & ~cmd_seen_r |=> err_r[`ERR_SUM]) // R9
    else $error("missing end command not flagged");
  AST_UNMAP: assert property ((st_r == init_run) & init_unmapped |=> err_r[`ERR_UNMAP]) // R10
    else $error("unmapped init not flagged");
  AST_IGN_SUM: assert property (ign_sum & (st_r == init_run) & init_end & cmd_seen_r & !err_r[`ERR_SUM] |=> // R11
    !err_r[`ERR_SUM]) else $error("checksum error while ignored");
  AST_IGN_ARB: assert property (arb_lost_evt & ign_arb |=> !arb_retry && !arb_abort) // R12
    else $error("arbitration acted while ignored");
  AST_SET_WINS: assert property (nack_evt & access & pwrite & hit(paddr, `STS_OFF) |=> err_r[`ERR_NACK]) // R13
    else $error("clear beat a same-cycle set");
  AST_RSVD: assert property (pready_r & ~pwrite & hit(paddr, `STS_OFF) |-> (prdata_r & `STS_RSVD_MASK) == `ZERO_WORD) // R14
    else $error("reserved bits read nonzero");

  COV_ABORT: cover property (arb_abort);
  COV_INIT_OK: cover property ((st_r == init_run) ##1 (st_r == init_fin) && err_r == '0);
  COV_CLEAR: cover property (access & pwrite & hit(paddr, `STS_OFF) & (err_r != '0));
endmodule : smbus_status
`default_nettype wire

// ---- smbus_regs.svh ----
// register map, field positions and reset values of the bus status block
// assumes 32-bit apb data and 12-bit byte addresses
`ifndef SMBUS_STATUS_REGS_SVH
`define SMBUS_STATUS_REGS_SVH
`define STS_OFF 12'h424
`define CTL_OFF 12'h428
`define SADDR_HI 7
`define SADDR_LO 1
`define MADDR_HI 15
`define MADDR_LO 9
`define DONE_BIT 24
`define ERR_HI 29
`define ERR_LO 25
`define IGN_ARB_BIT 16
`define IGN_SUM_BIT 17
`define STS_RSVD_MASK 32'hc0ff0101
`define ERR_NACK 0
`define ERR_ARB 1
`define ERR_COND 2
`define ERR_SUM 3
`define ERR_UNMAP 4
`define ARB_LAST 4'hf
`define ARB_CLR 4'h0
`define ARB_STEP 4'h1
`define STRAP_READY 2'h3
`define ZERO_ADDR 7'h00
`define ZERO_WORD 32'h00000000
`define ZERO_SUM 8'h00
`endif

// ---- smbus_status_pkg.sv ----
// types shared by the bus status block
// assumes smbus_regs.svh for numeric constants
package smbus_status_pkg;
  typedef enum logic [1:0] {init_idle, init_run, init_fin} init_state_t; // eeprom init progress
  typedef logic [3:0] arb_cnt_t; // consecutive arbitration losses
  typedef logic [4:0] err_vec_t; // sticky error flags, status bits 29:25
endpackage : smbus_status_pkg

// ---- bus_cond_detect.sv ----
// finds start and stop conditions on the two-wire management bus
// assumes scl and sda arrive asynchronously and are slower than pclk
`timescale 1ns/100ps
`default_nettype none
module bus_cond_detect (
  input wire logic pclk, // core clock
  input wire logic presetn, // async reset, active low
  input wire logic scl_in, // bus clock pin level
  input wire logic sda_in, // bus data pin level
  output logic start_det, // one-cycle pulse on start
  output logic stop_det // one-cycle pulse on stop
);
  logic [1:0] scl_sync_r; // two-flop synchroniser for scl
  logic [1:0] sda_sync_r; // two-flop synchroniser for sda
  logic scl_d_r; // previous synchronised scl
  logic sda_d_r; // previous synchronised sda
  logic start_r, start_nxt; // registered start pulse
  logic stop_r, stop_nxt; // registered stop pulse

  // conditions: sda moves while scl stays high; only stage two is looked at
  always_comb begin
    start_nxt = scl_sync_r[1] & scl_d_r & sda_d_r & ~sda_sync_r[1];
    stop_nxt = scl_sync_r[1] & scl_d_r & ~sda_d_r & sda_sync_r[1];
  end

  // synchronisers, history and pulse registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r <= 1'h1;
      sda_d_r <= 1'h1;
      start_r <= 1'h0;
      stop_r <= 1'h0;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      scl_d_r <= scl_sync_r[1];
      sda_d_r <= sda_sync_r[1];
      start_r <= start_nxt;
      stop_r <= stop_nxt;
    end
  end

  assign start_det = start_r;
  assign stop_det = stop_r;
endmodule : bus_cond_detect
`default_nettype wire

// ---- smbus_partner.sv ----
// partner model: eeprom image source and other devices on the bus pins
// assumes bench pclk; pins idle high through pull-ups
`timescale 1ns/100ps
`default_nettype none
module smbus_partner (
  input wire logic pclk, // core clock
  output logic scl_in, // bus clock pin level
  output logic sda_in, // bus data pin level
  output logic init_byte_vld, // image byte strobe
  output logic [7:0] init_byte, // image byte
  output logic init_cmd_done, // end command seen
  output logic init_end, // image read finished
  output logic init_unmapped // image targets unmapped register
);
  // idle levels at time zero
  initial begin
    scl_in = 1'b1;
    sda_in = 1'b1;
    init_byte_vld = 1'b0;
    init_byte = 8'h5a;
    init_cmd_done = 1'b0;
    init_end = 1'b0;
    init_unmapped = 1'b0;
  end
  // start, two link clock pulses at 320 ns, stop; the clock stands still outside
  task automatic frame();
    #7 sda_in = 1'b0; // start: data falls while clock high
    #160 scl_in = 1'b0;
    #160 scl_in = 1'b1;
    #160 scl_in = 1'b0;
    #160 scl_in = 1'b1;
    #160 sda_in = 1'b1; // stop: data rises while clock high
    #160;
  endtask : frame
  // n random bytes, then a sum byte that zeroes the total unless bad
  task automatic send_image(input int n, input bit bad, input bit cmd, input bit unmap);
    logic [7:0] sum;
    logic [7:0] b;
    sum = 8'h00;
    for (int i = 0; i <= n; i++) begin
      b = (i == n) ? 8'h00 - sum + {7'h00, bad} : 8'($urandom);
      sum = sum + b;
      init_byte_vld <= 1'b1;
      init_byte <= b;
      @(posedge pclk);
    end
    init_byte_vld <= 1'b0;
    init_byte <= ~b; // released byte lane shows no stale value
    init_cmd_done <= cmd;
    @(posedge pclk);
    init_cmd_done <= 1'b0;
    init_end <= !unmap;
    init_unmapped <= unmap;
    @(posedge pclk);
    init_end <= 1'b0;
    init_unmapped <= 1'b0;
  endtask : send_image
endmodule : smbus_partner
`default_nettype wire

// ---- smbus_status_test.sv ----
// self-checking bench of the bus status block
// assumes smbus_partner drives pins and image; bench drives apb, straps, engine events
`timescale 1ns/100ps
`default_nettype none
`include "smbus_regs.svh"
module smbus_status_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [6:0] sad, mad; // strap values
  logic init_mode_strap, scl_in, sda_in, byte_active, nack_evt, arb_lost_evt, arb_won_evt;
  logic init_byte_vld, init_cmd_done, init_end, init_unmapped, arb_retry, arb_abort;
  logic [7:0] init_byte;
  int num_errors, total_checks;
  smbus_status dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slave_addr_strap(sad), .master_addr_strap(mad), .init_mode_strap(init_mode_strap),
    .scl_in(scl_in), .sda_in(sda_in), .byte_active(byte_active), .nack_evt(nack_evt),
    .arb_lost_evt(arb_lost_evt), .arb_won_evt(arb_won_evt), .init_byte_vld(init_byte_vld),
    .init_byte(init_byte), .init_cmd_done(init_cmd_done), .init_end(init_end),
    .init_unmapped(init_unmapped), .arb_retry(arb_retry), .arb_abort(arb_abort));
  smbus_partner partner (.pclk(pclk), .scl_in(scl_in), .sda_in(sda_in), .init_byte_vld(init_byte_vld),
    .init_byte(init_byte), .init_cmd_done(init_cmd_done), .init_end(init_end), .init_unmapped(init_unmapped));
  // 25 mhz core clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // compares and counts
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // verdict and end of run
  task automatic conclude();
    if (num_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  // one apb transfer; clash holds an engine nack high through the access phase, landing edge included
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input bit clash,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    nack_evt <= clash;
    for (int n = 1; n <= 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        rd = prdata;
        err = pslverr;
        break;
      end
      if (n == 20) begin
        num_errors++;
        conclude();
      end
    end
    nack_evt <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // plain write
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, 1'b0, r, e);
  endtask : wr
  // read and compare
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, 1'b0, r, e);
    check(r, exp);
  endtask : rchk
  // reset with fresh random straps
  task automatic do_reset(input logic mode);
    presetn <= 1'b0;
    sad <= 7'($urandom);
    mad <= 7'($urandom);
    init_mode_strap <= mode;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : do_reset
  // expected status word
  function automatic logic [31:0] sts(input logic done, input logic [4:0] e);
    return {2'b00, e, done, 8'h00, mad, 1'b0, sad, 1'b0};
  endfunction : sts
  // one engine arbitration outcome; exp is {abort, retry} one cycle later
  task automatic lose(input logic won, input logic [1:0] exp);
    arb_lost_evt <= !won;
    arb_won_evt <= won;
    @(posedge pclk);
    arb_lost_evt <= 1'b0;
    arb_won_evt <= 1'b0;
    @(posedge pclk);
    check({30'h0, arb_abort, arb_retry}, {30'h0, exp});
  endtask : lose
  // main sequence
  initial begin
    logic [31:0] r;
    logic e;
    int k;
    presetn = 1'b0;
    {psel, penable, pwrite, byte_active, nack_evt, arb_lost_evt, arb_won_evt} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    {sad, mad, init_mode_strap} = 15'h0000;
    num_errors = 0;
    total_checks = 0;
    void'($urandom(51));
    // image cases: good, bad sum, no end command, bad sum ignored, unmapped, init off
    for (int c = 0; c < 6; c++) begin
      do_reset(c != 5);
      rchk(`STS_OFF, sts(1'b0, 5'h00));
      rchk(`CTL_OFF, 32'h00000000);
      if (c == 3) wr(`CTL_OFF, 32'h00020000);
      partner.send_image($urandom_range(6, 1), c == 1 || c == 3, c != 2, c == 4);
      repeat (2) @(posedge pclk);
      rchk(`STS_OFF, sts(c != 5, {c == 4, c == 1 || c == 2, 3'b000}));
    end
    apb(1'b0, 12'h430, 32'h00000000, 1'b0, r, e);
    check({r[31:1], e}, 32'h00000001);
    nack_evt <= 1'b1;
    @(posedge pclk);
    nack_evt <= 1'b0;
    rchk(`STS_OFF, sts(1'b0, 5'h01));
    apb(1'b1, `STS_OFF, 32'hffffffff, 1'b1, r, e);
    rchk(`STS_OFF, sts(1'b0, 5'h01));
    wr(`STS_OFF, 32'hffffffff);
    rchk(`STS_OFF, sts(1'b0, 5'h00));
    k = $urandom_range(14, 1);
    for (int i = 0; i < k; i++) lose(1'b0, 2'b01);
    lose(1'b1, 2'b00);
    for (int i = 0; i < 15; i++) lose(1'b0, 2'b01);
    lose(1'b0, 2'b10);
    rchk(`STS_OFF, sts(1'b0, 5'h02));
    lose(1'b0, 2'b01);
    wr(`STS_OFF, 32'h04000000);
    wr(`CTL_OFF, 32'h00010000);
    rchk(`CTL_OFF, 32'h00010000);
    for (int i = 0; i < 20; i++) lose(1'b0, 2'b00);
    rchk(`STS_OFF, sts(1'b0, 5'h00));
    byte_active <= 1'b1;
    partner.frame();
    repeat (8) @(posedge pclk);
    byte_active <= 1'b0;
    rchk(`STS_OFF, sts(1'b0, 5'h04));
    wr(`STS_OFF, 32'h08000000);
    partner.frame();
    repeat (8) @(posedge pclk);
    rchk(`STS_OFF, sts(1'b0, 5'h00));
    conclude();
  end
endmodule : smbus_status_test
`default_nettype wire
